/* phd_defs.svh */
// How it works
// - Calls enter base+2000 privileged, base+3000 unprivileged
// - Bad or non-kernel call function raises illegal-opcode
// - Call target built from base and function bits
// - Next PC saved and pushed on return stack
// - Call issues to E1, stalls only for barrier
// - Call occupies at least four cycles
// - Trap saves return PC, barrier, pushes stack PC
// - Twelve trap offsets in fixed priority order
// - Sign error hides data miss; icache miss reorders
// - Float-disabled trap on disabled or bad-type FP
// - Halt, drain-aborts, memory barrier functions supported
// - Reserved opcodes trap outside handler mode
// - Hardware-enable bit allows reserved opcodes in kernel
// - Physical bit bypasses checks; alternate picks mode
// - Write-check bit adds write fault checks
// - Page-table bit forces kernel, marks double miss
// - Ten-bit displacement, length bit, no alignment traps
// - Store always E0; conditional writes lock flag
// - Return jumps to saved address, bit0 sets mode
// - Type 10 prefetches early, 11 holds fetch
// - PC bit0 marks handler mode, fetch ignores it
`ifndef PHD_DEFS_SVH
`define PHD_DEFS_SVH
// ---------------------------------------------
// Register offsets and fields
// ---------------------------------------------
`define PHD_OFS_BASE   8'h00
`define PHD_OFS_CTRL   8'h08
`define PHD_OFS_EXC    8'h10
`define PHD_OFS_STAT   8'h18
`define PHD_B_HWE      0
`define PHD_B_FPE      1
`define PHD_MODE_KERNEL 2'h0
`define PHD_RST_BASE   64'h0000_0000_0000_0000
`define PHD_RST_CTRL   64'h0000_0000_0000_0000
// ---------------------------------------------
// Instruction fields
// ---------------------------------------------
`define PHD_OP_CALL    6'h00
`define PHD_OP_LD      6'h1B
`define PHD_OP_ST      6'h1F
`define PHD_OP_RET     6'h1E
`define PHD_OP_PRRD    6'h19
`define PHD_OP_PRWR    6'h1D
`define PHD_B_PHYSICAL_ADDR_BIT     15
`define PHD_B_ALT      14
`define PHD_B_WCHK     13
`define PHD_B_QUAD     12
`define PHD_B_PAGE_TABLE_FETCH_BIT     11
`define PHD_B_LOCK     10
`define PHD_FN_MAX     26'h000_00BF
`define PHD_RT_EARLY   2'h2
`define PHD_RT_STALL   2'h3
// ---------------------------------------------
// Trap indices and timing
// ---------------------------------------------
`define PHD_T_ITBM     4'h3
`define PHD_T_DTBM     4'h4
`define PHD_T_DTBD     4'h5
`define PHD_T_ILL      4'h9
`define PHD_T_FEN      4'hB
`define PHD_FLOW_CYC   2'h2
`endif

/* phd_pkg.sv */
package phd_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_CBAR = 3'h1,
      ST_CISS = 3'h2,
      ST_FLOW = 3'h3,
      ST_TBAR = 3'h4,
      ST_RISS = 3'h5
   } phd_state_t;
endpackage : phd_pkg

/* phd_dispatch.sv */
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "phd_defs.svh"
module phd_dispatch (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic [7:0]  bus_addr,
   input  wire logic [63:0] bus_wdata,
   input  wire logic        bus_wr,
   input  wire logic        bus_rd,
   output logic      [63:0] bus_rdata_r,
   input  wire logic        ins_valid,
   input  wire logic [31:0] ins_word,
   input  wire logic [63:0] ins_pc,
   input  wire logic        ins_fp,
   input  wire logic        ins_fp_badtype,
   input  wire logic        pipe_empty,
   input  wire logic [11:0] trap_req,
   input  wire logic        icache_miss,
   input  wire logic        sign_err,
   input  wire logic        trap_precise,
   input  wire logic [63:0] trap_ret_pc,
   input  wire logic [63:0] trap_inst_pc,
   input  wire logic [63:0] trap_late_pc,
   input  wire logic        lock_flag,
   output logic             redirect_r,
   output logic      [63:0] redirect_pc_r,
   output logic      [63:0] fetch_pc_r,
   output logic             rps_push_r,
   output logic      [63:0] rps_pc_r,
   output logic             stall_r,
   output logic             issue_e0_r,
   output logic             issue_e1_r,
   output logic             handler_mode_r,
   output logic             fetch_hold_r,
   output logic             early_fetch_r,
   output logic             mem_req_r,
   output logic             mem_store_r,
   output logic             mem_physical_addr_bit_r,
   output logic             mem_alt_r,
   output logic             mem_wchk_r,
   output logic             mem_kern_r,
   output logic             mem_quad_r,
   output logic             mem_lock_r,
   output logic             mem_noalign_r,
   output logic      [63:0] mem_displacement_field_r,
   output logic             conditional_bit_wb_r,
   output logic             conditional_bit_val_r,
   output logic             preg_rd_r,
   output logic             preg_wr_r
);
   // ---------------------------------------------
   // Decode helpers
   // ---------------------------------------------
   function automatic logic call_bad(input logic [25:0] f, input logic kern);
      call_bad = (f > `PHD_FN_MAX) || (f[7:6] == 2'h1)
                 || (f[7:6] == 2'h0 && !kern);
   endfunction : call_bad

   // Lowest set request wins; index is also the offset / 80 hex
   function automatic logic [4:0] pick(input logic [11:0] r, input logic current_mode_field);
      logic [4:0] p;
      p = 5'h00;
      // Icache miss lets the ITB miss jump ahead of a pending interrupt
      if (current_mode_field && r[`PHD_T_ITBM] && !r[1] && !r[0]) begin
         p = {1'b1, `PHD_T_ITBM};
      end else begin
         for (int i = 11; i >= 0; i--) begin
            if (r[i]) begin
               p = {1'b1, 4'(i)};
            end
         end
      end
      pick = p;
   endfunction : pick

   phd_pkg::phd_state_t st_r, st_nxt;
   logic [63:0] base_r, base_nxt, ctrl_r, ctrl_nxt, exc_r, exc_nxt;
   logic [63:0] tgt_r, tgt_nxt, rps_r, rpsn_nxt, rd_nxt;
   logic [3:0]  tidx_r, tidx_nxt;
   logic [1:0]  cnt_r, cnt_nxt;
   logic        page_table_fetch_bit_r, page_table_fetch_bit_nxt, mode_nxt;
   logic        redir_nxt, push_nxt, stall_nxt, e0_nxt, e1_nxt;
   logic        hold_nxt, early_nxt, mreq_nxt, mst_nxt, physical_addr_bit_nxt, alt_nxt;
   logic        wchk_nxt, kern_nxt, quad_nxt, lock_nxt, cwb_nxt, cval_nxt;
   logic        prd_nxt, pwr_nxt;
   logic [63:0] displacement_field_nxt;
   logic [5:0]  opc;
   logic [25:0] fn;
   logic        kern, priv_ok, fen_hit, ill_hit;
   logic [11:0] req;
   logic [4:0]  sel;
   logic [63:0] nxt_pc;

   assign opc    = ins_word[31:26];
   assign fn     = ins_word[25:0];
   assign kern   = ctrl_r[4:3] == `PHD_MODE_KERNEL;
   assign priv_ok = handler_mode_r || (ctrl_r[`PHD_B_HWE] && kern);
   assign nxt_pc = {ins_pc[63:1], 1'b0} + 64'h0000_0000_0000_0004;
   assign fen_hit = ins_valid && ins_fp
                    && (!ctrl_r[`PHD_B_FPE] || ins_fp_badtype);
   assign ill_hit = ins_valid && !priv_ok && (opc == `PHD_OP_LD
                    || opc == `PHD_OP_ST || opc == `PHD_OP_RET
                    || opc == `PHD_OP_PRRD || opc == `PHD_OP_PRWR);

   // Data miss goes double when the last priv load was a page-table fetch
   always_comb begin
      req = trap_req;
      req[`PHD_T_DTBM] = trap_req[`PHD_T_DTBM] && !page_table_fetch_bit_r && !sign_err;
      req[`PHD_T_DTBD] = (trap_req[`PHD_T_DTBD]
                          || (trap_req[`PHD_T_DTBM] && page_table_fetch_bit_r)) && !sign_err;
      sel = pick(req, icache_miss);
   end

   // ---------------------------------------------
   // Next-state logic
   // ---------------------------------------------
   always_comb begin
      st_nxt = st_r;
      base_nxt = base_r;
      ctrl_nxt = ctrl_r;
      exc_nxt = exc_r;
      tgt_nxt = tgt_r;
      rpsn_nxt = rps_r;
      tidx_nxt = tidx_r;
      cnt_nxt = cnt_r;
      page_table_fetch_bit_nxt = page_table_fetch_bit_r;
      mode_nxt = handler_mode_r;
      rd_nxt = 64'h0000_0000_0000_0000;
      {redir_nxt, push_nxt, stall_nxt, e0_nxt, e1_nxt} = 5'h00;
      {hold_nxt, early_nxt, mreq_nxt, mst_nxt, physical_addr_bit_nxt, alt_nxt} = 6'h00;
      {wchk_nxt, kern_nxt, quad_nxt, lock_nxt, cwb_nxt, cval_nxt} = 6'h00;
      {prd_nxt, pwr_nxt} = 2'h0;
      displacement_field_nxt = mem_displacement_field_r;
      if (bus_wr) begin
         case (bus_addr)
            `PHD_OFS_BASE: base_nxt = bus_wdata;
            `PHD_OFS_CTRL: ctrl_nxt = {59'h0, bus_wdata[4:3], 1'b0, bus_wdata[1:0]};
            `PHD_OFS_EXC:  exc_nxt = bus_wdata;
            default: ;
         endcase
      end
      if (bus_rd) begin
         case (bus_addr)
            `PHD_OFS_BASE: rd_nxt = base_r;
            `PHD_OFS_CTRL: rd_nxt = ctrl_r;
            `PHD_OFS_EXC:  rd_nxt = exc_r;
            `PHD_OFS_STAT: rd_nxt = {56'h0, tidx_r, st_r, handler_mode_r};
            default: rd_nxt = 64'h0000_0000_0000_0000;
         endcase
      end
      case (st_r)
         phd_pkg::ST_IDLE: begin
            if (sel[4]) begin
               st_nxt = phd_pkg::ST_TBAR;
               tidx_nxt = sel[3:0];
               tgt_nxt = trap_ret_pc;
               rpsn_nxt = trap_precise ? trap_inst_pc : trap_late_pc;
               stall_nxt = 1'b1;
            end else if (ill_hit || fen_hit
                         || (ins_valid && opc == `PHD_OP_CALL && call_bad(fn, kern))) begin
               st_nxt = phd_pkg::ST_TBAR;
               tidx_nxt = fen_hit ? `PHD_T_FEN : `PHD_T_ILL;
               tgt_nxt = ins_pc;
               rpsn_nxt = ins_pc;
               stall_nxt = 1'b1;
            end else if (ins_valid) begin
               case (opc)
                  `PHD_OP_CALL: begin
                     st_nxt = phd_pkg::ST_CBAR;
                     stall_nxt = 1'b1;
                     tgt_nxt = {base_r[63:14], 1'b1, fn[7], fn[5:0], 5'h00, 1'b1};
                     rpsn_nxt = nxt_pc;
                  end
                  `PHD_OP_LD, `PHD_OP_ST: begin
                     mreq_nxt = 1'b1;
                     mst_nxt = opc == `PHD_OP_ST;
                     physical_addr_bit_nxt = ins_word[`PHD_B_PHYSICAL_ADDR_BIT];
                     alt_nxt = ins_word[`PHD_B_ALT];
                     quad_nxt = ins_word[`PHD_B_QUAD];
                     displacement_field_nxt = {{54{ins_word[9]}}, ins_word[9:0]};
                     if (opc == `PHD_OP_LD) begin
                        wchk_nxt = ins_word[`PHD_B_WCHK];
                        kern_nxt = ins_word[`PHD_B_PAGE_TABLE_FETCH_BIT];
                        page_table_fetch_bit_nxt = ins_word[`PHD_B_PAGE_TABLE_FETCH_BIT];
                        lock_nxt = ins_word[`PHD_B_LOCK];
                        e0_nxt = ins_word[`PHD_B_LOCK];
                        e1_nxt = !ins_word[`PHD_B_LOCK];
                     end else begin
                        e0_nxt = 1'b1;
                        cwb_nxt = ins_word[`PHD_B_LOCK];
                        cval_nxt = lock_flag;
                     end
                  end
                  `PHD_OP_RET: begin
                     st_nxt = phd_pkg::ST_RISS;
                     hold_nxt = ins_word[15:14] == `PHD_RT_STALL;
                     early_nxt = ins_word[15:14] == `PHD_RT_EARLY;
                     tgt_nxt = exc_r;
                  end
                  `PHD_OP_PRRD: prd_nxt = 1'b1;
                  `PHD_OP_PRWR: pwr_nxt = 1'b1;
                  default: ;
               endcase
            end
         end
         phd_pkg::ST_CBAR: begin
            stall_nxt = !pipe_empty;
            if (pipe_empty) begin
               st_nxt = phd_pkg::ST_CISS;
            end
         end
         phd_pkg::ST_CISS: begin
            st_nxt = phd_pkg::ST_FLOW;
            cnt_nxt = `PHD_FLOW_CYC;
            e1_nxt = 1'b1;
            redir_nxt = 1'b1;
            push_nxt = 1'b1;
            exc_nxt = {rps_r[63:1], handler_mode_r};
            mode_nxt = 1'b1;
         end
         phd_pkg::ST_FLOW: begin
            cnt_nxt = cnt_r - 2'h1;
            if (cnt_r == 2'h1) begin
               st_nxt = phd_pkg::ST_IDLE;
            end
         end
         phd_pkg::ST_TBAR: begin
            stall_nxt = !pipe_empty;
            if (pipe_empty) begin
               st_nxt = phd_pkg::ST_IDLE;
               redir_nxt = 1'b1;
               push_nxt = 1'b1;
               exc_nxt = {tgt_r[63:1], handler_mode_r};
               tgt_nxt = {base_r[63:14], 3'h0, tidx_r, 6'h00, 1'b1};
               mode_nxt = 1'b1;
            end
         end
         phd_pkg::ST_RISS: begin
            st_nxt = phd_pkg::ST_IDLE;
            e1_nxt = 1'b1;
            redir_nxt = 1'b1;
            mode_nxt = exc_r[0];
         end
         default: st_nxt = phd_pkg::ST_IDLE;
      endcase
   end

   // ---------------------------------------------
   // Registers
   // ---------------------------------------------
   // Hardware writes of the saved address land after software ones in the
   // comb block, so a same-cycle bus write loses
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_r <= phd_pkg::ST_IDLE;
         base_r <= `PHD_RST_BASE;
         ctrl_r <= `PHD_RST_CTRL;
         exc_r <= 64'h0000_0000_0000_0001;
         tgt_r <= 64'h0000_0000_0000_0000;
         rps_r <= 64'h0000_0000_0000_0000;
         tidx_r <= 4'h0;
         cnt_r <= 2'h0;
         page_table_fetch_bit_r <= 1'b0;
         handler_mode_r <= 1'b1;
         bus_rdata_r <= 64'h0000_0000_0000_0000;
         redirect_pc_r <= 64'h0000_0000_0000_0001;
         fetch_pc_r <= 64'h0000_0000_0000_0000;
         rps_pc_r <= 64'h0000_0000_0000_0000;
         mem_displacement_field_r <= 64'h0000_0000_0000_0000;
         {redirect_r, rps_push_r, stall_r, issue_e0_r, issue_e1_r} <= 5'h00;
         {fetch_hold_r, early_fetch_r, mem_req_r, mem_store_r} <= 4'h0;
         {mem_physical_addr_bit_r, mem_alt_r, mem_wchk_r, mem_kern_r} <= 4'h0;
         {mem_quad_r, mem_lock_r, mem_noalign_r, conditional_bit_wb_r} <= 4'h0;
         {conditional_bit_val_r, preg_rd_r, preg_wr_r} <= 3'h0;
      end else begin
         st_r <= st_nxt;
         base_r <= base_nxt;
         ctrl_r <= ctrl_nxt;
         exc_r <= exc_nxt;
         tgt_r <= tgt_nxt;
         rps_r <= rpsn_nxt;
         tidx_r <= tidx_nxt;
         cnt_r <= cnt_nxt;
         page_table_fetch_bit_r <= page_table_fetch_bit_nxt;
         handler_mode_r <= mode_nxt;
         bus_rdata_r <= rd_nxt;
         if (redir_nxt) begin
            redirect_pc_r <= (st_r == phd_pkg::ST_TBAR) ? tgt_nxt : tgt_r;
            fetch_pc_r <= (st_r == phd_pkg::ST_TBAR)
                          ? {tgt_nxt[63:2], 2'h0} : {tgt_r[63:2], 2'h0};
         end
         if (push_nxt) begin
            rps_pc_r <= rps_r;
         end
         mem_displacement_field_r <= displacement_field_nxt;
         {redirect_r, rps_push_r, stall_r, issue_e0_r, issue_e1_r}
            <= {redir_nxt, push_nxt, stall_nxt, e0_nxt, e1_nxt};
         fetch_hold_r <= hold_nxt;
         early_fetch_r <= early_nxt;
         {mem_req_r, mem_store_r, mem_physical_addr_bit_r, mem_alt_r}
            <= {mreq_nxt, mst_nxt, physical_addr_bit_nxt, alt_nxt};
         {mem_wchk_r, mem_kern_r, mem_quad_r, mem_lock_r}
            <= {wchk_nxt, kern_nxt, quad_nxt, lock_nxt};
         mem_noalign_r <= mreq_nxt;
         {conditional_bit_wb_r, conditional_bit_val_r, preg_rd_r, preg_wr_r}
            <= {cwb_nxt, cval_nxt, prd_nxt, pwr_nxt};
      end
   end

   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   property p_call_pc;
      @(posedge clk_sys) disable iff (rst)
      st_r == phd_pkg::ST_CISS |=> redirect_r && redirect_pc_r[13]
         && redirect_pc_r[5:0] == 6'h01 && redirect_pc_r[12] == $past(tgt_r[12]);
   endproperty
   a_call_pc: assert property (p_call_pc) else $error("bad call target");

   property p_bad_fn;
      @(posedge clk_sys) disable iff (rst)
      st_r == phd_pkg::ST_IDLE && !sel[4] && !fen_hit && ins_valid
         && opc == `PHD_OP_CALL && fn[7:6] == 2'h1
      |=> st_r == phd_pkg::ST_TBAR && tidx_r == `PHD_T_ILL;
   endproperty
   a_bad_fn: assert property (p_bad_fn) else $error("call not trapped");

   property p_push;
      @(posedge clk_sys) disable iff (rst)
      st_r == phd_pkg::ST_CISS |=> rps_push_r && rps_pc_r[63:1] == exc_r[63:1];
   endproperty
   a_push: assert property (p_push) else $error("return PC mismatch");

   property p_min4;
      @(posedge clk_sys) disable iff (rst)
      $rose(st_r == phd_pkg::ST_CBAR) |-> (st_r != phd_pkg::ST_IDLE)[*4];
   endproperty
   a_min4: assert property (p_min4) else $error("call too short");

   property p_e1;
      @(posedge clk_sys) disable iff (rst)
      st_r == phd_pkg::ST_CISS |=> issue_e1_r && !issue_e0_r && !stall_r;
   endproperty
   a_e1: assert property (p_e1) else $error("call not in E1");

   property p_trap;
      @(posedge clk_sys) disable iff (rst)
      st_r == phd_pkg::ST_TBAR && pipe_empty |=> redirect_r && handler_mode_r
         && redirect_pc_r[13:0] == {3'h0, $past(tidx_r), 7'h01};
   endproperty
   a_trap: assert property (p_trap) else $error("trap entry wrong");

   property p_rei;
      @(posedge clk_sys) disable iff (rst)
      st_r == phd_pkg::ST_RISS |=> handler_mode_r == $past(exc_r[0])
         && redirect_pc_r == $past(tgt_r);
   endproperty
   a_rei: assert property (p_rei) else $error("return mode wrong");

   property p_store;
      @(posedge clk_sys) disable iff (rst)
      mem_req_r && mem_store_r |-> issue_e0_r && mem_noalign_r;
   endproperty
   a_store: assert property (p_store) else $error("store not in E0");

   property p_sign;
      @(posedge clk_sys) disable iff (rst)
      sign_err |-> !req[`PHD_T_DTBM] && !req[`PHD_T_DTBD];
   endproperty
   a_sign: assert property (p_sign) else $error("data miss not hidden");

   c_call: cover property (@(posedge clk_sys) st_r == phd_pkg::ST_CISS);
   c_trap: cover property (@(posedge clk_sys) st_r == phd_pkg::ST_TBAR ##1 redirect_r);
   c_rei: cover property (@(posedge clk_sys) st_r == phd_pkg::ST_RISS && fetch_hold_r);
endmodule : phd_dispatch
`default_nettype wire

/* phd_pipe_model.sv */
`timescale 1ns/1ps
`default_nettype none
module phd_pipe_model (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       stall_r,
   input  wire logic [3:0] drain_cyc,
   output logic            pipe_empty
);
   // ------------------------------------------
   // Pipe drain
   // ------------------------------------------
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   // Empty only after the drain time; a slow pipe never reports early
   always_comb begin
      cnt_nxt = stall_r ? cnt_r + ((cnt_r == 4'hF) ? 4'h0 : 4'h1) : 4'h0;
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_r <= 4'h0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
   assign pipe_empty = stall_r && (cnt_r >= drain_cyc);
endmodule : phd_pipe_model
`default_nettype wire

/* phd_dispatch_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "phd_defs.svh"
module phd_dispatch_tb;
   logic clk_sys, rst, bus_wr, bus_rd, ins_valid, ins_fp, ins_fp_badtype, pipe_empty;
   logic icache_miss, sign_err, trap_precise, lock_flag;
   logic ef, fh, e0, e1, psh, st, cw, cv;
   logic [7:0]  bus_addr, mf;
   logic [3:0]  drain;
   logic [11:0] trap_req;
   logic [31:0] ins_word;
   logic [63:0] bus_wdata, ins_pc, trap_ret_pc, trap_inst_pc, trap_late_pc, bs;
   logic [25:0] fns [7];
   logic [5:0]  ops [5];
   wire logic [63:0] bus_rdata_r, redirect_pc_r, rps_pc_r, mem_displacement_field_r, fetch_pc_r;
   wire logic redirect_r, rps_push_r, stall_r, issue_e0_r, issue_e1_r, handler_mode_r;
   wire logic fetch_hold_r, early_fetch_r, mem_req_r, mem_store_r, mem_physical_addr_bit_r, mem_alt_r;
   wire logic mem_wchk_r, mem_kern_r, mem_quad_r, mem_lock_r, mem_noalign_r;
   wire logic conditional_bit_wb_r, conditional_bit_val_r, preg_rd_r, preg_wr_r;
   int mismatches, n_tests, n;
   phd_dispatch dut (.*);
   phd_pipe_model u_pipe (.clk_sys(clk_sys), .rst(rst), .stall_r(stall_r), .drain_cyc(drain),
                          .pipe_empty(pipe_empty));
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // ------------------------------------------
   // Tasks
   // ------------------------------------------
   task automatic summarize;
      $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : summarize
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [63:0] cpc(input logic [7:0] f);
      cpc = {bs[63:14], 1'b1, f[7], f[5:0], 5'h00, 1'b1};
   endfunction : cpc
   function automatic logic [63:0] tpc(input int i);
      tpc = {bs[63:14], 14'h0000} + 64'(i * 128) + 64'h1;
   endfunction : tpc
   task automatic bwr(input logic [7:0] a, input logic [63:0] d);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk_sys);
      bus_wr <= 1'b0;
   endtask : bwr
   task automatic brd(input logic [7:0] a, input logic [63:0] exp);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk_sys);
      bus_rd <= 1'b0;
      #1 chk(bus_rdata_r, exp);
   endtask : brd
   // Sel: 0 redirect, 1 memory request, 2 register read, 3 register write
   task automatic wt(input int sel);
      {ef, fh, e0, e1, psh, st, cw, cv} = 8'h00;
      n = 0;
      #1;
      forever begin
         ef |= early_fetch_r;
         fh |= fetch_hold_r;
         e0 |= issue_e0_r;
         e1 |= issue_e1_r;
         psh |= rps_push_r;
         st |= stall_r;
         if (conditional_bit_wb_r === 1'b1) {cw, cv} = {1'b1, conditional_bit_val_r};
         if (mem_req_r === 1'b1) mf = {mem_store_r, mem_physical_addr_bit_r, mem_alt_r, mem_wchk_r, mem_kern_r,
                                      mem_quad_r, mem_lock_r, mem_noalign_r};
         if ((sel == 0 && redirect_r === 1'b1) || (sel == 1 && mem_req_r === 1'b1) ||
             (sel == 2 && preg_rd_r === 1'b1) || (sel == 3 && preg_wr_r === 1'b1)) break;
         if (n == 40) begin
            mismatches++;
            $display("ERROR timeout t=%0t sel=%h", $time, sel);
            summarize();
         end
         @(posedge clk_sys);
         #1 n++;
      end
   endtask : wt
   task automatic go(input logic [31:0] w, input logic fp, input logic bad, input int sel);
      @(posedge clk_sys);
      {ins_valid, ins_word, ins_fp, ins_fp_badtype} <= {1'b1, w, fp, bad};
      @(posedge clk_sys);
      {ins_valid, ins_fp, ins_fp_badtype} <= 3'h0;
      wt(sel);
      repeat (4) @(posedge clk_sys);
   endtask : go
   task automatic trp(input logic [11:0] req, input logic im, input logic se);
      @(posedge clk_sys);
      {trap_req, icache_miss, sign_err} <= {req, im, se};
      // Drop the level once taken, else the idle state takes it a second time
      @(posedge clk_sys);
      {trap_req, icache_miss, sign_err} <= 14'h0000;
      wt(0);
      repeat (4) @(posedge clk_sys);
   endtask : trp
   task automatic lv(input logic [1:0] t);
      bwr(`PHD_OFS_EXC, 64'h0000_0000_0000_1000);
      go({`PHD_OP_RET, 10'h000, t, 14'h0000}, 1'b0, 1'b0, 0);
   endtask : lv
   // ------------------------------------------
   // Main sequence
   // ------------------------------------------
   initial begin
      {rst, bus_wr, bus_rd, ins_valid, ins_fp, ins_fp_badtype, icache_miss, sign_err} = 8'h80;
      {bus_addr, trap_req, ins_word, bus_wdata, drain, mismatches, n_tests} = '0;
      {trap_precise, lock_flag, bs} = {2'h3, 64'hFEDC_BA98_7654_C000};
      ins_pc = 64'h0000_0000_0040_1230;
      trap_ret_pc = 64'h0000_0000_0000_5670;
      trap_inst_pc = 64'h0000_0000_0000_5678;
      trap_late_pc = 64'h0000_0000_0000_567C;
      fns = '{26'h000_0000, 26'h000_0002, 26'h000_0086, 26'h000_00BF, 26'h000_0040, 26'h000_007F, 26'h100_0002};
      ops = '{`PHD_OP_LD, `PHD_OP_ST, `PHD_OP_RET, `PHD_OP_PRRD, `PHD_OP_PRWR};
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      brd(`PHD_OFS_EXC, 64'h1);
      brd(8'h20, 64'h0);
      chk(handler_mode_r, 64'h1);
      bwr(`PHD_OFS_BASE, bs);
      drain <= 4'h3;
      go(32'h0000_0002, 1'b0, 1'b0, 0);
      chk(redirect_pc_r, cpc(8'h02));
      chk(fetch_pc_r, cpc(8'h02) & ~64'h3);
      chk({e1, psh, st, 1'(n >= 2)}, 64'hF);
      chk(rps_pc_r, ins_pc + 64'h4);
      brd(`PHD_OFS_EXC, ins_pc + 64'h5);
      drain <= 4'h0;
      for (int md = 0; md < 2; md++) begin
         bwr(`PHD_OFS_CTRL, (md == 1) ? 64'h18 : 64'h0);
         foreach (fns[i]) begin
            go({`PHD_OP_CALL, fns[i]}, 1'b0, 1'b0, 0);
            chk(redirect_pc_r, ((fns[i] >= 26'h40 && fns[i] <= 26'h7F) || fns[i] > 26'hBF ||
                (fns[i] <= 26'h3F && md == 1)) ? tpc(9) : cpc(fns[i][7:0]));
         end
      end
      for (int i = 1; i < 12; i++) begin
         trp(12'h001 << i, 1'b0, 1'b0);
         chk(redirect_pc_r, tpc(i));
      end
      chk(rps_pc_r, trap_inst_pc);
      chk(fetch_pc_r, tpc(11) & ~64'h3);
      brd(`PHD_OFS_EXC, trap_ret_pc + 64'h1);
      trap_precise <= 1'b0;
      trp(12'hA08, 1'b0, 1'b0);
      chk({redirect_pc_r, rps_pc_r}, {tpc(3), trap_late_pc});
      trp(12'h00C, 1'b1, 1'b0);
      chk(redirect_pc_r, tpc(3));
      trp(12'h00C, 1'b0, 1'b0);
      chk(redirect_pc_r, tpc(2));
      trp(12'h090, 1'b0, 1'b1);
      chk(redirect_pc_r, tpc(7));
      // Locked load slotted to E0 by handler code
      go({`PHD_OP_LD, 10'h000, 6'h2F, 10'h3FF}, 1'b0, 1'b0, 1);
      chk({mf, e0}, {8'h5F, 1'b1});
      chk(mem_displacement_field_r, 64'hFFFF_FFFF_FFFF_FFFF);
      trp(12'h010, 1'b0, 1'b0);
      chk(redirect_pc_r, tpc(5));
      go({`PHD_OP_ST, 10'h000, 6'h11, 10'h004}, 1'b0, 1'b0, 1);
      chk({mf & 8'hE5, e0, cw, cv}, {8'hA1, 3'h7});
      chk(mem_displacement_field_r, 64'h4);
      go({`PHD_OP_PRRD, 26'h000_0000}, 1'b0, 1'b0, 2);
      lv(2'h3);
      chk({redirect_pc_r[0], handler_mode_r, fh, e1}, 64'h3);
      // Outside handler mode here: each reserved opcode traps, then return
      foreach (ops[i]) begin
         go({ops[i], 26'h000_0000}, 1'b0, 1'b0, 0);
         chk(redirect_pc_r, tpc(9));
         lv(2'h2);
         chk({ef, handler_mode_r}, 64'h2);
      end
      bwr(`PHD_OFS_CTRL, 64'h1);
      lv(2'h2);
      go({`PHD_OP_PRWR, 26'h000_0000}, 1'b0, 1'b0, 3);
      chk(handler_mode_r, 64'h0);
      bwr(`PHD_OFS_CTRL, 64'h0);
      go({6'h16, 26'h000_0000}, 1'b1, 1'b0, 0);
      chk(redirect_pc_r, tpc(11));
      lv(2'h2);
      bwr(`PHD_OFS_CTRL, 64'h2);
      go({6'h16, 26'h000_0000}, 1'b1, 1'b1, 0);
      chk(redirect_pc_r, tpc(11));
      brd(`PHD_OFS_STAT, 64'hB1);
      summarize();
   end
endmodule : phd_dispatch_tb
`default_nettype wire
